// ---- core/rdrg_core.sv ----
// rs-485 driver-enable timing, transmit interrupt shaping and receive gating for a uart
//
// Overview of operation
// - half duplex drives enable high while tx pending
// - half duplex withholds tx interrupt until shifter empty
// - large block gives normal fifo tx interrupts
// - snoop bit gates storing only in half duplex/infrared, timeout in all modes
// - snoop plus half duplex stores all received data
// - half duplex and infrared off gives normal full duplex receive
// - half duplex without snoop blocks receive at all times unless loopback is selected
// - infrared without snoop rejects echo, snoop accepts
// - snoop clear kills timeout interrupt, even rs-232
// - delay field sets bit times enable stays high
// - delay starts once shifter and fifo empty
// - holding fifo write cancels running delay
// - loopback off, snoop set: full receive everywhere
// - loopback off, snoop clear, half/ir: no receive
// - bit one selects infrared serial mode
// - register at address 010 when lcr key 100
// - enable rises before first stop bit
`timescale 1ns/1ps
`default_nettype none
module rdrg_core
  import rdrg_pkg::*;
(
  // clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  // host register access
  input  wire rdrg_pkg::rdrg_host_req_t host_i,
  output logic [7:0]                  rdata_o,
  output logic                        rsel_o,
  // transmitter status and loopback select from the uart
  input  wire rdrg_pkg::rdrg_tx_stat_t  tx_i,
  input  wire logic                   loopback_select_i,
  // transceiver and uart controls
  output logic                        halfduplex_de_o,
  output logic                        tx_irq_cond_o,
  output logic                        infrared_mode_enable_o,
  output rdrg_pkg::rdrg_rx_gate_t       rx_gate_o
);

  // ********************************************************************
  // state
  // ********************************************************************
  typedef struct packed {
    logic [7:0]     afc;
    logic [7:0]     rdata;
    logic           rsel;
    rdrg_de_state_t de_st;
    logic           de;
    logic           tx_irq;
    logic           ir_en;
    rdrg_rx_gate_t  rx_gate;
  } rdrg_core_state_t;

  localparam rdrg_core_state_t CORE_RESET = '{
    afc:     RDRG_AFC_RESET,
    rdata:   8'h00,
    rsel:    1'b0,
    de_st:   DE_IDLE,
    de:      1'b0,
    tx_irq:  1'b0,
    ir_en:   1'b0,
    rx_gate: '0
  };

  rdrg_core_state_t s_q;
  rdrg_core_state_t s_d;

  // selects the register only under the lcr key
  function automatic logic afc_hit(input rdrg_host_req_t r);
    afc_hit = (r.addr == RDRG_AFC_ADDR) && (r.lcr_sel == RDRG_AFC_LCR_KEY);
  endfunction

  // ********************************************************************
  // decoded fields
  // ********************************************************************
  logic                  hd_en;
  logic                  lg_blk;
  logic                  snoop;
  logic                  ir_en;
  logic [RDRG_DLY_W-1:0] dly;
  logic                  tx_pending;
  logic                  tx_drained;
  logic                  tmr_start;
  logic                  tmr_cancel;
  logic                  tmr_busy;
  logic                  tmr_done;

  always_comb begin
    hd_en      = s_q.afc[RDRG_HDEN_BIT];
    lg_blk     = s_q.afc[RDRG_LGBLK_BIT];
    snoop      = s_q.afc[RDRG_SNOOP_BIT];
    ir_en      = s_q.afc[RDRG_INFRARED_MODE_ENABLE_BIT];
    dly        = s_q.afc[RDRG_DLY_LSB +: RDRG_DLY_W];
    tx_drained = tx_i.fifo_empty && tx_i.shift_empty;
    tx_pending = !tx_drained;
  end

  // ********************************************************************
  // next state
  // ********************************************************************
  always_comb begin
    s_d        = s_q;
    tmr_start  = 1'b0;
    tmr_cancel = 1'b0;

    // reserved bit 0 is not stored and reads as zero
    if (host_i.wr && afc_hit(host_i)) begin
      s_d.afc = host_i.wdata & RDRG_AFC_WMASK;
    end
    s_d.rsel  = host_i.rd && afc_hit(host_i);
    s_d.rdata = (host_i.rd && afc_hit(host_i)) ? s_q.afc : 8'h00;

    s_d.ir_en = ir_en;

    // driver enable sequencing
    unique case (s_q.de_st)
      DE_IDLE: begin
        s_d.de = 1'b0;
        // pending data raises enable well ahead of the first stop bit
        if (hd_en && (tx_pending || tx_i.thr_write || tx_i.pre_stop)) begin
          s_d.de_st = DE_SEND;
          s_d.de    = 1'b1;
        end
      end
      DE_SEND: begin
        s_d.de = 1'b1;
        if (!hd_en) begin
          s_d.de_st = DE_IDLE;
          s_d.de    = 1'b0;
        end else if (tx_drained && !tx_i.thr_write) begin
          tmr_start = 1'b1;
          s_d.de_st = DE_TURN;
        end
      end
      DE_TURN: begin
        s_d.de = 1'b1;
        if (!hd_en) begin
          tmr_cancel = 1'b1;
          s_d.de_st  = DE_IDLE;
          s_d.de     = 1'b0;
        end else if (tx_i.thr_write || tx_pending) begin
          tmr_cancel = 1'b1;
          s_d.de_st  = DE_SEND;
        end else if (tmr_done) begin
          s_d.de_st = DE_IDLE;
          s_d.de    = 1'b0;
        end
      end
    endcase

    // half duplex without large block waits for the shifter to drain
    if (hd_en && !lg_blk) begin
      s_d.tx_irq = tx_drained;
    end else begin
      s_d.tx_irq = tx_i.fifo_below_thr || tx_i.fifo_empty;
    end

    // receive gating; the snoop bit gates storing only in half duplex or infrared, timeout in every mode
    if (loopback_select_i) begin
      s_d.rx_gate.store_en       = 1'b1;
      s_d.rx_gate.thr_err_irq_en = 1'b1;
    end else if (!(hd_en || ir_en)) begin
      s_d.rx_gate.store_en       = 1'b1;
      s_d.rx_gate.thr_err_irq_en = 1'b1;
    end else begin
      // blocking rather than only while sending: echo and bus traffic alike are dropped
      s_d.rx_gate.store_en       = snoop;
      s_d.rx_gate.thr_err_irq_en = snoop;
    end
    // timeout needs snoop in every mode, loopback included
    s_d.rx_gate.timeout_irq_en = snoop && s_d.rx_gate.store_en;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= CORE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // ********************************************************************
  // turnaround timer
  // ********************************************************************
  rdrg_turn_timer #(
    .CNT_W (RDRG_DLY_W)
  ) u_turn_timer (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .start_i    (tmr_start),
    .cancel_i   (tmr_cancel),
    .bit_tick_i (tx_i.bit_tick),
    .length_i   (dly),
    .busy_o     (tmr_busy),
    .done_o     (tmr_done)
  );

  // ********************************************************************
  // outputs
  // ********************************************************************
  assign rdata_o                = s_q.rdata;
  assign rsel_o                 = s_q.rsel;
  assign halfduplex_de_o        = s_q.de;
  assign tx_irq_cond_o          = s_q.tx_irq;
  assign infrared_mode_enable_o = s_q.ir_en;
  assign rx_gate_o              = s_q.rx_gate;

  // ********************************************************************
  // checks
  // ********************************************************************
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic hd_irq_ref;
  assign hd_irq_ref = tx_drained;
  logic lg_irq_ref;
  assign lg_irq_ref = tx_i.fifo_below_thr || tx_i.fifo_empty;

  sequence s_drain_in_send;
    (s_q.de_st == DE_SEND) && hd_en && tx_drained && !tx_i.thr_write;
  endsequence

  sequence s_turn_quiet;
    (s_q.de_st == DE_TURN) && hd_en && tx_drained && !tx_i.thr_write;
  endsequence

  a_de_on_pending: assert property (hd_en && tx_pending |=> halfduplex_de_o)
    else $error("driver enable low while data pending");

  a_de_off_no_hd: assert property (!hd_en |=> !halfduplex_de_o)
    else $error("driver enable high with half duplex off");

  // a zero delay ends the turnaround in its first cycle, so only a real delay must hold the enable
  a_turn_holds: assert property (s_drain_in_send ##1 (s_turn_quiet and (dly != '0)) |=> halfduplex_de_o)
    else $error("driver enable dropped at start of turnaround");

  a_turn_zero_len: assert property ((s_drain_in_send and (dly == '0)) ##1 s_turn_quiet
                                    |=> !halfduplex_de_o)
    else $error("zero delay did not release driver enable");

  a_turn_cancel: assert property ((s_q.de_st == DE_TURN) && hd_en && tx_i.thr_write
                                  |=> (s_q.de_st == DE_SEND) && halfduplex_de_o && !tmr_busy)
    else $error("holding write did not cancel turnaround");

  a_tx_irq_hd: assert property (hd_en && !lg_blk |=> tx_irq_cond_o == $past(hd_irq_ref))
    else $error("half duplex tx interrupt not held for shifter");

  a_tx_irq_lg: assert property (lg_blk |=> tx_irq_cond_o == $past(lg_irq_ref))
    else $error("large block tx interrupt not fifo based");

  a_rx_blocked: assert property (!loopback_select_i && !snoop && (hd_en || ir_en)
                                 |=> !rx_gate_o.store_en && !rx_gate_o.thr_err_irq_en)
    else $error("receive not blocked without snoop");

  a_rx_snoop_all: assert property (!loopback_select_i && snoop |=> rx_gate_o.store_en
                                   && rx_gate_o.thr_err_irq_en && rx_gate_o.timeout_irq_en)
    else $error("snoop did not enable full receive");

  a_rx_duplex: assert property (!loopback_select_i && !hd_en && !ir_en |=> rx_gate_o.store_en)
    else $error("full duplex receive gated");

  a_timeout_gate: assert property (!snoop |=> !rx_gate_o.timeout_irq_en)
    else $error("timeout interrupt enabled without snoop");

  a_loop_store: assert property (loopback_select_i |=> rx_gate_o.store_en && rx_gate_o.thr_err_irq_en)
    else $error("looped data not stored");

  a_afc_locked: assert property (host_i.wr && (host_i.lcr_sel != RDRG_AFC_LCR_KEY) |=> $stable(s_q.afc))
    else $error("register written without lcr key");

  a_ir_follow: assert property (host_i.wr && afc_hit(host_i)
                                |=> ##1 infrared_mode_enable_o == $past(host_i.wdata[RDRG_INFRARED_MODE_ENABLE_BIT], 2))
    else $error("infrared enable did not follow write");

endmodule
`default_nettype wire

// ---- core/rdrg_pkg.sv ----
// package: register map, field layout and carrier types for the rs-485 direction and rx gating block
package rdrg_pkg;

  // ********************************************************************
  // register location and reset
  // ********************************************************************
  localparam logic [2:0] RDRG_AFC_ADDR      = 3'h2;
  localparam logic [2:0] RDRG_AFC_LCR_KEY   = 3'h4;
  localparam logic [7:0] RDRG_AFC_RESET     = 8'h00;
  localparam logic [7:0] RDRG_AFC_WMASK     = 8'hFE;

  // ********************************************************************
  // field positions of alternate_function_control
  // ********************************************************************
  localparam int         RDRG_INFRARED_MODE_ENABLE_BIT      = 1;
  localparam int         RDRG_HDEN_BIT      = 2;
  localparam int         RDRG_LGBLK_BIT     = 3;
  localparam int         RDRG_SNOOP_BIT     = 4;
  localparam int         RDRG_DLY_LSB       = 5;
  localparam int         RDRG_DLY_W         = 3;

  // ********************************************************************
  // carriers
  // ********************************************************************
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [2:0] lcr_sel;
  } rdrg_host_req_t;

  typedef struct packed {
    logic fifo_empty;
    logic shift_empty;
    logic fifo_below_thr;
    logic thr_write;
    logic pre_stop;
    logic bit_tick;
  } rdrg_tx_stat_t;

  typedef struct packed {
    logic store_en;
    logic thr_err_irq_en;
    logic timeout_irq_en;
  } rdrg_rx_gate_t;

  typedef enum logic [1:0] {
    DE_IDLE,
    DE_SEND,
    DE_TURN
  } rdrg_de_state_t;

endpackage

// ---- core/rdrg_turn_timer.sv ----
// turnaround timer: counts bit times after the transmitter has drained
`timescale 1ns/1ps
`default_nettype none
module rdrg_turn_timer #(
  parameter int CNT_W = 3
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // control
  input  wire logic             start_i,
  input  wire logic             cancel_i,
  input  wire logic             bit_tick_i,
  input  wire logic [CNT_W-1:0] length_i,
  // status
  output logic                  busy_o,
  output logic                  done_o
);

  typedef struct packed {
    logic             run;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] len;
    logic             done;
  } rdrg_tmr_state_t;

  localparam rdrg_tmr_state_t TMR_RESET = '0;

  rdrg_tmr_state_t s_q;
  rdrg_tmr_state_t s_d;

  always_comb begin
    s_d      = s_q;
    s_d.done = 1'b0;
    if (cancel_i) begin
      s_d.run = 1'b0;
    end else if (start_i) begin
      // a zero length finishes at once, without waiting for a tick
      s_d.run  = (length_i != '0);
      s_d.done = (length_i == '0);
      s_d.cnt  = '0;
      s_d.len  = length_i;
    end else if (s_q.run && bit_tick_i) begin
      s_d.cnt = s_q.cnt + 1'b1;
      if ((s_q.cnt + 1'b1) == s_q.len) begin
        s_d.run  = 1'b0;
        s_d.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= TMR_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign busy_o = s_q.run;
  assign done_o = s_q.done;

  // ********************************************************************
  // checks
  // ********************************************************************
  a_zero_len_done: assert property (@(posedge clk_i) disable iff (rst_i)
    start_i && !cancel_i && (length_i == '0) |=> done_o && !busy_o)
    else $error("zero turnaround length did not finish next cycle");

endmodule
`default_nettype wire

// ---- verif/rdrg_line_model.sv ----
// line partner: transmitter bit pacing and a transceiver that drives only when enabled
`timescale 1ns/1ps
`default_nettype none
module rdrg_line_model #(
  parameter int BIT_CYC = 4
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // driver enable from the block
  input  wire logic de_i,
  // bit pacing and line activity
  output logic      bit_tick_o,
  output logic      line_driven_o
);
  int cnt_q;

  // free-running bit pace; phase is unrelated to any transfer
  always_ff @(posedge clk_i) begin
    if (rst_i || cnt_q == BIT_CYC - 1) begin
      cnt_q <= 0;
    end else begin
      cnt_q <= cnt_q + 1;
    end
    bit_tick_o <= !rst_i && cnt_q == BIT_CYC - 1;
    line_driven_o <= !rst_i && de_i;
  end
endmodule
`default_nettype wire

// ---- verif/testbench.sv ----
// testbench: register access, receive gating, tx interrupt shaping, driver enable timing
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import rdrg_pkg::*;
  localparam int BIT_CYC = 4;
  logic           clk_i = 1'b0;
  logic           rst_i = 1'b1;
  rdrg_host_req_t host  = '0;
  logic           fe = 1'b1, se = 1'b1, blw = 1'b0, tw = 1'b0, ps = 1'b0, lb = 1'b0;
  wire logic      tick;
  rdrg_tx_stat_t  tx;
  logic [7:0]     rdata;
  logic           rsel, de, txi, ir;
  rdrg_rx_gate_t  gate;
  int             mismatches = 0;
  int             checked = 0;
  int             cyc, ticks;
  logic [7:0]     modes [6] = '{8'h10, 8'h14, 8'h12, 8'h00, 8'h04, 8'h02};
  logic [11:0]    tcase [6] = '{12'h04A, 12'h04D, 12'h0C3, 12'h0C9, 12'h0C0, 12'h003};

  assign tx = '{fifo_empty: fe, shift_empty: se, fifo_below_thr: blw,
                thr_write: tw, pre_stop: ps, bit_tick: tick};

  always #10 clk_i = ~clk_i;

  rdrg_core u_dut (.clk_i(clk_i), .rst_i(rst_i), .host_i(host), .rdata_o(rdata),
    .rsel_o(rsel), .tx_i(tx), .loopback_select_i(lb), .halfduplex_de_o(de),
    .tx_irq_cond_o(txi), .infrared_mode_enable_o(ir), .rx_gate_o(gate));

  rdrg_line_model #(.BIT_CYC(BIT_CYC)) u_line (.clk_i(clk_i), .rst_i(rst_i),
    .de_i(de), .bit_tick_o(tick), .line_driven_o());

  // ********************************************************************
  // shared tasks
  // ********************************************************************
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [2:0] a, input logic [2:0] key, input logic [7:0] d);
    @(posedge clk_i);
    host <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0, lcr_sel: key};
    @(posedge clk_i);
    host.wr <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask

  task automatic rd_reg(input logic [2:0] a, input logic [2:0] key, input logic [7:0] exp,
                        input logic sel);
    @(posedge clk_i);
    host <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1, lcr_sel: key};
    @(posedge clk_i);
    host.rd <= 1'b0;
    @(negedge clk_i);
    chk("rdata", rdata, exp);
    chk("rsel", {7'h00, rsel}, {7'h00, sel});
  endtask

  // hand the transmitter empty, then count cycles and bit ticks until the enable drops
  task automatic drain();
    @(posedge clk_i);
    fe <= 1'b1;
    se <= 1'b1;
    cyc = 0;
    ticks = 0;
    do begin
      @(negedge clk_i);
      cyc++;
      if (de === 1'b1 && tick === 1'b1) ticks++;
    end while (de === 1'b1 && cyc < 200);
  endtask

  task automatic de_after(input logic [7:0] exp, input int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
    chk("de", {7'h00, de}, exp);
  endtask

  function automatic logic [2:0] gate_exp(input logic [7:0] r, input logic l);
    logic s;
    s = l | ~(r[1] | r[2]) | r[4];
    return {s, s, r[4] & s};
  endfunction

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ********************************************************************
  // tests
  // ********************************************************************
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_reg(RDRG_AFC_ADDR, RDRG_AFC_LCR_KEY, 8'h00, 1'b1);
    wr_reg(RDRG_AFC_ADDR, RDRG_AFC_LCR_KEY, 8'hFF);
    rd_reg(RDRG_AFC_ADDR, RDRG_AFC_LCR_KEY, 8'hFE, 1'b1);
    wr_reg(RDRG_AFC_ADDR, 3'h0, 8'h00);
    wr_reg(3'h3, RDRG_AFC_LCR_KEY, 8'h00);
    rd_reg(RDRG_AFC_ADDR, RDRG_AFC_LCR_KEY, 8'hFE, 1'b1);
    rd_reg(3'h3, RDRG_AFC_LCR_KEY, 8'h00, 1'b0);
    $display("test register access done");

    foreach (modes[i]) begin
      for (int l = 0; l < 2; l++) begin
        @(posedge clk_i);
        lb <= l[0];
        wr_reg(RDRG_AFC_ADDR, RDRG_AFC_LCR_KEY, modes[i]);
        @(negedge clk_i);
        chk("rx_gate", {5'h00, gate}, {5'h00, gate_exp(modes[i], l[0])});
        chk("ir_mode", {7'h00, ir}, {7'h00, modes[i][1]});
      end
    end
    lb <= 1'b0;
    $display("test receive gating done");

    // large block only ever set together with half duplex
    foreach (tcase[i]) begin
      wr_reg(RDRG_AFC_ADDR, RDRG_AFC_LCR_KEY, tcase[i][11:4]);
      @(posedge clk_i);
      {fe, se, blw} <= tcase[i][3:1];
      repeat (2) @(posedge clk_i);
      @(negedge clk_i);
      chk("tx_irq", {7'h00, txi}, {7'h00, tcase[i][0]});
    end
    blw <= 1'b0;
    drain();
    $display("test tx interrupt done");

    wr_reg(RDRG_AFC_ADDR, RDRG_AFC_LCR_KEY, 8'h04);
    fe <= 1'b0;
    se <= 1'b0;
    de_after(8'h01, 2);
    fe <= 1'b1;
    de_after(8'h01, 20);
    drain();
    chk("d0_drop", {7'h00, cyc inside {[3:4]}}, 8'h01);
    wr_reg(RDRG_AFC_ADDR, RDRG_AFC_LCR_KEY, 8'h44);
    fe <= 1'b0;
    de_after(8'h01, 2);
    drain();
    chk("d2_ticks", {7'h00, ticks inside {[2:3]}}, 8'h01);
    wr_reg(RDRG_AFC_ADDR, RDRG_AFC_LCR_KEY, 8'hE4);
    se <= 1'b0;
    de_after(8'h01, 2);
    se <= 1'b1;
    repeat (10) @(posedge clk_i);
    tw <= 1'b1;
    @(posedge clk_i);
    tw <= 1'b0;
    de_after(8'h01, 24);
    drain();
    chk("d7_drop", {7'h00, cyc < 200}, 8'h01);
    $display("test driver enable delay done");

    wr_reg(RDRG_AFC_ADDR, RDRG_AFC_LCR_KEY, 8'h04);
    ps <= 1'b1;
    @(posedge clk_i);
    ps <= 1'b0;
    de_after(8'h01, 1);
    drain();
    wr_reg(RDRG_AFC_ADDR, RDRG_AFC_LCR_KEY, 8'hE0);
    fe <= 1'b0;
    de_after(8'h00, 4);
    fe <= 1'b1;
    $display("test enable rise and disable done");
    wrap_up();
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    wrap_up();
  end
endmodule
`default_nettype wire
